// *** rtl/cau_crc_accumulator_unit.sv ***
/*
 crc accumulator unit: byte-wide crc engine behind three special-function
 registers (control, input byte, result data port).
 assumes single-cycle core register accesses on the same clock.
*/
// How it works
// - select bit 0 computes a 32-bit crc with polynomial 04C11DB7.
// - select bit 1 computes a 16-bit crc with polynomial 1021.
// - writing one to init loads the whole result with the chosen preset.
// - preset is all zeros when value select is 0, all ones otherwise.
// - two-bit pointer picks result byte; increments after each data port access.
// - 32-bit mode: pointer 0..3 selects bytes 0..3 in order.
// - 16-bit mode: even pointer selects low byte, odd selects high byte.
// - control bits 7 to 5 read zero and ignore writes.
// - 16-bit: xor byte into top eight bits, then eight shift-xor steps.
// - 16-bit results match the published single-byte reference vectors.
`timescale 1ns/100ps
module cau_crc_accumulator_unit
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic [31:0] crc_result_out
);
    logic poly_width_select_reg;
    logic init_value_select_reg;
    logic [1:0] result_byte_pointer_reg;
    logic [31:0] result_reg;
    logic [7:0] data_byte;
    logic [7:0] rd_ctrl_reg;
    logic rd_data_reg;
    logic wr_ctrl;
    logic wr_input;
    logic data_access;
    logic init_write;
    logic data_write;
    logic rd_data;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == cau_pkg::CTRL_ADDR);
    assign wr_input = reg_wr_in && (reg_addr_in == cau_pkg::INPUT_ADDR);
    assign data_access = (reg_wr_in || reg_rd_in) && (reg_addr_in == cau_pkg::DATA_ADDR);
    assign init_write = wr_ctrl && reg_wdata_in[cau_pkg::INIT_BIT];
    assign data_write = reg_wr_in && data_access;
    assign rd_data = reg_rd_in && data_access;

    // 16-bit update: byte into the top of the low half, msb first
    function automatic logic [15:0] crc16_byte(input logic [15:0] acc,
                                               input logic [7:0] din);
        logic [15:0] a;
        a = acc;
        a[15:8] = a[15:8] ^ din;
        for (int i = 0; i < cau_pkg::STEPS; i++)
        begin
            if (a[15])
            begin
                a = {a[14:0], 1'b0} ^ cau_pkg::POLY16;
            end
            else
            begin
                a = {a[14:0], 1'b0};
            end
        end
        return a;
    endfunction

    // 32-bit update: byte into the top eight bits, msb first
    function automatic logic [31:0] crc32_byte(input logic [31:0] acc,
                                               input logic [7:0] din);
        logic [31:0] a;
        a = acc;
        a[31:24] = a[31:24] ^ din;
        for (int i = 0; i < cau_pkg::STEPS; i++)
        begin
            if (a[31])
            begin
                a = {a[30:0], 1'b0} ^ cau_pkg::POLY32;
            end
            else
            begin
                a = {a[30:0], 1'b0};
            end
        end
        return a;
    endfunction

    // one byte through eight shift-xor steps; 16-bit mode clears the upper half
    function automatic logic [31:0] crc_byte(input logic [31:0] acc,
                                             input logic [7:0] din,
                                             input logic w16);
        logic [31:0] a;
        if (w16)
        begin
            a = {16'h0000, crc16_byte(acc[15:0], din)};
        end
        else
        begin
            a = crc32_byte(acc, din);
        end
        return a;
    endfunction

    // control byte as software sees it: unused bits and init always read zero
    function automatic logic [7:0] ctrl_image(input logic w16,
                                              input logic val,
                                              input logic [1:0] ptr);
        return {cau_pkg::CTRL_UNUSED, w16, 1'b0, val, ptr};
    endfunction

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            poly_width_select_reg <= cau_pkg::CTRL_RESET[cau_pkg::SEL_BIT];
        end
        else if (wr_ctrl)
        begin
            poly_width_select_reg <= reg_wdata_in[cau_pkg::SEL_BIT];
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            init_value_select_reg <= cau_pkg::CTRL_RESET[cau_pkg::VAL_BIT];
        end
        else if (wr_ctrl)
        begin
            init_value_select_reg <= reg_wdata_in[cau_pkg::VAL_BIT];
        end
    end

    // a control write sets the pointer; data port accesses advance it
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            result_byte_pointer_reg <= cau_pkg::CTRL_RESET[cau_pkg::PNT_HI:cau_pkg::PNT_LO];
        end
        else if (wr_ctrl)
        begin
            result_byte_pointer_reg <= reg_wdata_in[cau_pkg::PNT_HI:cau_pkg::PNT_LO];
        end
        else if (data_access)
        begin
            result_byte_pointer_reg <= result_byte_pointer_reg + cau_pkg::PNT_STEP;
        end
    end

    // init uses the value select bit written in the same access
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            result_reg <= cau_pkg::PRESET_ZERO;
        end
        else if (init_write)
        begin
            result_reg <= reg_wdata_in[cau_pkg::VAL_BIT] ? cau_pkg::PRESET_ONES
                                                         : cau_pkg::PRESET_ZERO;
        end
        else if (wr_input)
        begin
            result_reg <= crc_byte(result_reg, reg_wdata_in, poly_width_select_reg);
        end
        else if (data_write)
        begin
            if (poly_width_select_reg)
            begin
                result_reg[result_byte_pointer_reg[0]*8 +: 8] <= reg_wdata_in;
            end
            else
            begin
                result_reg[result_byte_pointer_reg*8 +: 8] <= reg_wdata_in;
            end
        end
    end

    cau_byte_sel u_byte_sel
    (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .result_in(result_reg),
        .pointer_in(result_byte_pointer_reg),
        .width16_in(poly_width_select_reg),
        .byte_out(data_byte)
    );

    // read data lags the read strobe by one cycle, like the byte selector
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_ctrl_reg <= cau_pkg::CTRL_RESET;
        end
        else
        begin
            rd_ctrl_reg <= ctrl_image(poly_width_select_reg, init_value_select_reg,
                                      result_byte_pointer_reg);
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_data_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data;
        end
    end

    assign reg_rdata_out = rd_data_reg ? data_byte : rd_ctrl_reg;
    assign crc_result_out = result_reg;
endmodule // cau_crc_accumulator_unit

// *** rtl/cau_pkg.sv ***
/*
 package for the crc accumulator unit: register offsets, field positions,
 polynomials and preset values.
 assumes an 8-bit special-function-register access port from the core.
*/
package cau_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h92;
    localparam logic [7:0] INPUT_ADDR = 8'h91;
    localparam logic [7:0] DATA_ADDR = 8'h93;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int SEL_BIT = 4;
    localparam int INIT_BIT = 3;
    localparam int VAL_BIT = 2;
    localparam int PNT_HI = 1;
    localparam int PNT_LO = 0;
    localparam logic [2:0] CTRL_UNUSED = 3'h0;
    localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
    localparam logic [15:0] POLY16 = 16'h1021;
    localparam logic [31:0] PRESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] PRESET_ONES = 32'hFFFF_FFFF;
    localparam int STEPS = 8;
    localparam logic [1:0] PNT_STEP = 2'h1;
endpackage

// *** rtl/cau_byte_sel.sv ***
/*
 byte selector for the result data port: picks the result byte named by
 the pointer, folding the pointer in 16-bit mode.
 assumes the result is presented whole, registered output.
*/
`timescale 1ns/100ps
module cau_byte_sel
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [31:0] result_in,
    input wire logic [1:0] pointer_in,
    input wire logic width16_in,
    output logic [7:0] byte_out
);
    logic [1:0] eff_ptr;
    always_comb
    begin
        eff_ptr = pointer_in;
        if (width16_in)
        begin
            eff_ptr = {1'b0, pointer_in[0]};
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            byte_out <= cau_pkg::RDATA_RESET;
        end
        else
        begin
            byte_out <= result_in[eff_ptr*8 +: 8];
        end
    end
endmodule // cau_byte_sel

// *** verif/cau_assertions.sv ***
/*
 port checker for the crc accumulator unit.
 assumes one clock domain; bound onto the top module below.
*/
`timescale 1ns/100ps
module cau_assertions
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [31:0] crc_result_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic cw;
    logic dr;
    assign cw = reg_wr_in && reg_addr_in == 8'h92;
    assign dr = reg_rd_in && reg_addr_in == 8'h93;
    property p_init_zero;
        cw && reg_wdata_in[3] && !reg_wdata_in[2] |=> crc_result_out == 32'h0000_0000;
    endproperty
    a_init_zero: assert property (p_init_zero) else $error("preset zero missed");
    property p_init_ones;
        cw && reg_wdata_in[3] && reg_wdata_in[2] |=> crc_result_out == 32'hFFFF_FFFF;
    endproperty
    a_init_ones: assert property (p_init_ones) else $error("preset ones missed");
    property p_ctrl_read;
        cw ##1 (reg_rd_in && reg_addr_in == 8'h92) |=>
            reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h17);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_upper_zero;
        cw && reg_wdata_in[4] ##1 (reg_wr_in && reg_addr_in == 8'h91) |=>
            crc_result_out[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper half not clear");
    property p_unmapped;
        reg_wr_in && !(reg_addr_in inside {8'h91, 8'h92, 8'h93}) |=> $stable(crc_result_out);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write changed result");
    property p_read_keeps;
        reg_rd_in |=> $stable(crc_result_out);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed result");
    property p_fold16;
        cw && reg_wdata_in[4] && !reg_wdata_in[3] ##1 dr |=> reg_rdata_out ==
            ($past(reg_wdata_in[0], 2) ? crc_result_out[15:8] : crc_result_out[7:0]);
    endproperty
    a_fold16: assert property (p_fold16) else $error("16-bit byte select wrong");
    property p_sel32;
        cw && !reg_wdata_in[4] && !reg_wdata_in[3] ##1 dr |=> reg_rdata_out ==
            8'(crc_result_out >> {$past(reg_wdata_in[1:0], 2), 3'b000});
    endproperty
    a_sel32: assert property (p_sel32) else $error("32-bit byte select wrong");
endmodule // cau_assertions
bind cau_crc_accumulator_unit cau_assertions cau_assertions_inst
(
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .crc_result_out(crc_result_out)
);

// *** verif/cau_crc_accumulator_unit_bench.sv ***
/*
 bench for the crc accumulator unit: mode rows, then hand tests.
 assumes the bound checker is compiled alongside.
*/
`timescale 1ns/100ps
module cau_crc_accumulator_unit_bench;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [31:0] crc_result_out;
    int n_errors = 0;
    int checked = 0;
    // row: {width select, preset select, input byte, expected result}
    logic [41:0] rows [6] = '{42'h163_EFEE_5FFA, 42'h363_0000_BD35, 42'h28C_0000_5004,
                              42'h07D_D179_9B34, 42'h1FF_FFFF_FF00, 42'h300_0000_E1F0};
    logic [7:0] vec [5] = '{8'h00, 8'h00, 8'hAA, 8'hBB, 8'hCC};
    always #2.5 core_clk_in = ~core_clk_in;
    cau_crc_accumulator_unit cau_crc_accumulator_unit_inst
    (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .crc_result_out(crc_result_out)
    );
    // strobes held to the next edge; caller lowers them with an idle call
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr_in = w;
        reg_rd_in = r;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(posedge core_clk_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        logic [31:0] e;
        repeat (6) @(posedge core_clk_in);
        #1 nrst_in = 1'b1;
        chk(crc_result_out | {24'h00_0000, reg_rdata_out}, 32'h0000_0000);
        foreach (rows[k])
        begin
            bus(1'b1, 1'b0, 8'h92, {3'h0, rows[k][41], 1'b1, rows[k][40], 2'h0});
            bus(1'b1, 1'b0, 8'h91, rows[k][39:32]);
            e = rows[k][31:0];
            chk(crc_result_out, e);
            for (int p = 0; p < 4; p++)
            begin
                bus(1'b0, 1'b1, 8'h93, 8'h00);
                chk({24'h00_0000, reg_rdata_out},
                    {24'h00_0000, e[8 * (rows[k][41] ? p % 2 : p) +: 8]});
            end
        end
        for (int j = 0; j < 2; j++)
        begin
            bus(1'b1, 1'b0, 8'h92, 8'h1C);
            for (int k = 2 - 2 * j; k < 5; k++)
                bus(1'b1, 1'b0, 8'h91, vec[k]);
            chk(crc_result_out, j ? 32'h0000_B166 : 32'h0000_6CF6);
        end
        bus(1'b1, 1'b0, 8'h92, 8'h00);
        for (int k = 0; k < 4; k++)
            bus(1'b1, 1'b0, 8'h93, 8'(8'h11 * (k + 1)));
        chk(crc_result_out, 32'h4433_2211);
        bus(1'b1, 1'b0, 8'h92, 8'h03);
        bus(1'b0, 1'b1, 8'h93, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0044);
        bus(1'b0, 1'b1, 8'h93, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0011);
        bus(1'b1, 1'b0, 8'h92, 8'h11);
        bus(1'b0, 1'b1, 8'h93, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0022);
        bus(1'b0, 1'b1, 8'h93, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0011);
        bus(1'b1, 1'b0, 8'h93, 8'hAB);
        chk(crc_result_out, 32'h4433_AB11);
        bus(1'b1, 1'b0, 8'h92, 8'hFF);
        bus(1'b0, 1'b1, 8'h92, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0017);
        bus(1'b1, 1'b0, 8'h90, 8'h5A);
        chk(crc_result_out, 32'hFFFF_FFFF);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        nrst_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #1 nrst_in = 1'b1;
        chk(crc_result_out | {24'h00_0000, reg_rdata_out}, 32'h0000_0000);
        bus(1'b0, 1'b1, 8'h92, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0000);
        bus(1'b0, 1'b1, 8'h93, 8'h00);
        chk({24'h00_0000, reg_rdata_out}, 32'h0000_0000);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        end_of_test();
    end
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end
endmodule // cau_crc_accumulator_unit_bench
